//--- cpu_state_cfg.svh
// constants for the cpu architectural state block
`ifndef CPU_STATE_CFG_SVH
`define CPU_STATE_CFG_SVH
`define DS_GPR_FIRST 8'h00
`define DS_GPR_LAST 8'h1f
`define DS_SP_LOW 8'h5d
`define DS_SP_HIGH 8'h5e
`define DS_STATUS 8'h5f
`define IO_TO_DS_OFFSET 8'h20
`define PTR_X_LOW 5'h1a
`define PTR_Y_LOW 5'h1c
`define PTR_Z_LOW 5'h1e
`define FLAG_IE 7
`define FLAG_T 6
`define FLAG_H 5
`define FLAG_S 4
`define FLAG_V 3
`define FLAG_N 2
`define FLAG_Z 1
`define FLAG_C 0
`define STATUS_RESET 8'h00
`define SP_HIGH_BITS 3
`define LAST_SRAM_ADDRESS 11'h4ff
`endif

//--- cpu_state_pkg.sv
// types for the cpu architectural state block
package cpu_state_pkg;
  typedef enum logic [2:0] {
    SP_HOLD,
    SP_DEC1,
    SP_INC1,
    SP_DEC2,
    SP_INC2
  } sp_op_t;
  typedef enum logic [1:0] {
    PTR_NONE,
    PTR_POST_INC,
    PTR_PRE_DEC
  } ptr_mode_t;
  typedef struct packed {
    logic [7:0] flags;
    logic [10:0] sp;
  } core_state_t;
endpackage

//--- gpr_port_if.sv
// write and read bundle between the state block and its register file
`timescale 1ns/1ns
interface gpr_port_if;
  logic [4:0] rd_a_addr;
  logic [4:0] rd_b_addr;
  logic [7:0] rd_a_data;
  logic [7:0] rd_b_data;
  logic [15:0] rd_w_data;
  logic [4:0] rd_p_addr;
  logic [15:0] rd_p_data;
  logic [4:0] wr_addr;
  logic [7:0] wr_lo;
  logic [7:0] wr_hi;
  logic wr_en;
  logic wr_wide;
  modport owner (output rd_a_addr, rd_b_addr, rd_p_addr, wr_addr, wr_lo, wr_hi, wr_en, wr_wide,
                 input rd_a_data, rd_b_data, rd_w_data, rd_p_data);
  modport store (input rd_a_addr, rd_b_addr, rd_p_addr, wr_addr, wr_lo, wr_hi, wr_en, wr_wide,
                 output rd_a_data, rd_b_data, rd_w_data, rd_p_data);
endinterface

//--- gpr_bank.sv
// 32 by 8 working register array with byte and pair access
`timescale 1ns/1ns
module gpr_bank
  import cpu_state_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // access port
  gpr_port_if.store port
);
  logic [7:0] regs [32];
  logic [4:0] pair_hi;

  // wide write pairs an even register with the next one
  assign pair_hi = {port.wr_addr[4:1], 1'b1};

  // writes, low byte at the lower address
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) begin
        regs[i] <= 8'h00;
      end
    end else if (port.wr_en) begin
      if (port.wr_wide) begin
        regs[{port.wr_addr[4:1], 1'b0}] <= port.wr_lo;
        regs[pair_hi] <= port.wr_hi;
      end else begin
        regs[port.wr_addr] <= port.wr_lo;
      end
    end
  end

  // combinational reads, operand a doubles as a pair read
  assign port.rd_a_data = regs[port.rd_a_addr];
  assign port.rd_b_data = regs[port.rd_b_addr];
  assign port.rd_w_data = {regs[{port.rd_a_addr[4:1], 1'b1}], regs[{port.rd_a_addr[4:1], 1'b0}]};
  // dedicated pointer pair read, so displacement mode never steals operand a
  assign port.rd_p_data = {regs[{port.rd_p_addr[4:1], 1'b1}], regs[{port.rd_p_addr[4:1], 1'b0}]};
endmodule

//--- cpu_state_core.sv
// status flags, working registers, pointer pairs and stack pointer
`timescale 1ns/1ns
`include "cpu_state_cfg.svh"
module cpu_state_core
  import cpu_state_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // operand reads
  input wire logic [4:0] src_a_sel,
  input wire logic [4:0] src_b_sel,
  output logic [7:0] src_a_byte,
  output logic [7:0] src_b_byte,
  output logic [15:0] src_a_word,
  // result write
  input wire logic result_we,
  input wire logic result_wide,
  input wire logic [4:0] result_sel,
  input wire logic [15:0] result_data,
  // alu flag update
  input wire logic alu_update,
  input wire logic [7:0] alu_flag_mask,
  input wire logic alu_carry,
  input wire logic alu_half,
  input wire logic alu_overflow,
  input wire logic [15:0] alu_result,
  input wire logic alu_result_wide,
  // bit copy
  input wire logic bit_to_flag_copy,
  input wire logic flag_to_bit_copy,
  input wire logic [2:0] copy_bit_sel,
  // interrupt enable control
  input wire logic global_irq_set_op,
  input wire logic global_irq_clear_op,
  input wire logic irq_taken,
  input wire logic interrupt_exit,
  input wire logic irq_request_any,
  output logic irq_accept_ok,
  // stack operations
  input wire sp_op_t sp_op,
  output logic [10:0] stack_ptr,
  // pointer access
  input wire logic [1:0] ptr_sel,
  input wire ptr_mode_t ptr_mode,
  input wire logic [5:0] ptr_disp,
  output logic [15:0] ptr_addr,
  // data space access
  input wire logic ds_we,
  input wire logic ds_re,
  input wire logic [7:0] ds_addr,
  input wire logic [7:0] ds_wdata,
  output logic [7:0] ds_rdata,
  output logic ds_hit,
  // flags view
  output logic [7:0] status_flags_reg
);
  core_state_t cur;
  core_state_t next_cur;
  gpr_port_if gp();
  logic [4:0] ptr_low_idx;
  logic [15:0] ptr_value;
  logic [15:0] ptr_next;
  logic ptr_step;
  logic ds_gpr;
  logic [7:0] copy_src;
  logic [7:0] copy_result;

  gpr_bank u_bank (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .port(gp.store)
  );

  // io-space address to data-space address
  function automatic logic [7:0] io_to_ds(input logic [5:0] io_addr);
    io_to_ds = 8'({2'b00, io_addr}) + `IO_TO_DS_OFFSET;
  endfunction

  // index of the low byte of pointer x, y or z
  function automatic logic [4:0] ptr_index(input logic [1:0] sel);
    unique case (sel)
      2'd0: ptr_index = `PTR_X_LOW;
      2'd1: ptr_index = `PTR_Y_LOW;
      default: ptr_index = `PTR_Z_LOW;
    endcase
  endfunction

  // pointer selection and step
  assign ptr_low_idx = ptr_index(ptr_sel);
  assign ptr_step = (ptr_mode != PTR_NONE);
  always_comb begin
    ptr_next = ptr_value;
    ptr_addr = ptr_value + 16'({10'h000, ptr_disp});
    unique case (ptr_mode)
      PTR_POST_INC: begin
        ptr_next = ptr_value + 16'h0001;
        ptr_addr = ptr_value;
      end
      PTR_PRE_DEC: begin
        ptr_next = ptr_value - 16'h0001;
        ptr_addr = ptr_next;
      end
      PTR_NONE: begin
      end
    endcase
  end

  // data-space decode of the register window
  assign ds_gpr = (ds_addr <= `DS_GPR_LAST);
  assign ds_hit = ds_gpr || ds_addr == `DS_SP_LOW || ds_addr == `DS_SP_HIGH ||
                  ds_addr == `DS_STATUS;

  // bit copy between t flag and a register bit
  assign copy_src = gp.rd_a_data;
  always_comb begin
    copy_result = copy_src;
    copy_result[copy_bit_sel] = cur.flags[`FLAG_T];
  end

  // register file port arbitration, pointer update has priority over data writes
  always_comb begin
    gp.rd_a_addr = src_a_sel;
    gp.rd_b_addr = ds_re ? ds_addr[4:0] : src_b_sel;
    gp.rd_p_addr = ptr_low_idx;
    gp.wr_en = 1'b0;
    gp.wr_wide = 1'b0;
    gp.wr_addr = result_sel;
    gp.wr_lo = result_data[7:0];
    gp.wr_hi = result_data[15:8];
    if (ptr_step) begin
      gp.wr_en = 1'b1;
      gp.wr_wide = 1'b1;
      gp.wr_addr = ptr_low_idx;
      gp.wr_lo = ptr_next[7:0];
      gp.wr_hi = ptr_next[15:8];
    end else if (flag_to_bit_copy) begin
      gp.wr_en = 1'b1;
      gp.wr_addr = src_a_sel;
      gp.wr_lo = copy_result;
    end else if (result_we) begin
      gp.wr_en = 1'b1;
      gp.wr_wide = result_wide;
    end else if (ds_we && ds_gpr) begin
      gp.wr_en = 1'b1;
      gp.wr_addr = ds_addr[4:0];
      gp.wr_lo = ds_wdata;
    end
  end
  // pointer value feeds displacement as well as the step modes
  assign ptr_value = gp.rd_p_data;

  // next state: flags and stack pointer
  always_comb begin
    logic zero_res;
    logic neg_res;
    logic [7:0] f;
    zero_res = 1'b0;
    neg_res = 1'b0;
    next_cur = cur;
    f = cur.flags;
    // flag update from the alu, masked per operation
    if (alu_update) begin
      zero_res = alu_result_wide ? (alu_result == 16'h0000) : (alu_result[7:0] == 8'h00);
      neg_res = alu_result_wide ? alu_result[15] : alu_result[7];
      if (alu_flag_mask[`FLAG_C]) f[`FLAG_C] = alu_carry;
      if (alu_flag_mask[`FLAG_Z]) f[`FLAG_Z] = zero_res;
      if (alu_flag_mask[`FLAG_N]) f[`FLAG_N] = neg_res;
      if (alu_flag_mask[`FLAG_V]) f[`FLAG_V] = alu_overflow;
      if (alu_flag_mask[`FLAG_H]) f[`FLAG_H] = alu_half;
    end
    if (bit_to_flag_copy) begin
      f[`FLAG_T] = gp.rd_a_data[copy_bit_sel];
    end
    // software write of the flags register, S is then rederived from N and V below
    if (ds_we && ds_addr == `DS_STATUS) begin
      f = ds_wdata;
    end
    // global enable control, clear wins if both arrive
    if (global_irq_set_op || interrupt_exit) begin
      f[`FLAG_IE] = 1'b1;
    end
    if (global_irq_clear_op || irq_taken) begin
      f[`FLAG_IE] = 1'b0;
    end
    f[`FLAG_S] = f[`FLAG_N] ^ f[`FLAG_V];
    next_cur.flags = f;
    // stack pointer movement
    unique case (sp_op)
      SP_DEC1: next_cur.sp = cur.sp - 11'd1;
      SP_INC1: next_cur.sp = cur.sp + 11'd1;
      SP_DEC2: next_cur.sp = cur.sp - 11'd2;
      SP_INC2: next_cur.sp = cur.sp + 11'd2;
      SP_HOLD: next_cur.sp = cur.sp;
      default: next_cur.sp = cur.sp;
    endcase
    // software writes of the stack pointer bytes
    if (ds_we && ds_addr == `DS_SP_LOW) begin
      next_cur.sp[7:0] = ds_wdata;
    end
    if (ds_we && ds_addr == `DS_SP_HIGH) begin
      next_cur.sp[10:8] = ds_wdata[`SP_HIGH_BITS-1:0];
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur.flags <= `STATUS_RESET;
      cur.sp <= `LAST_SRAM_ADDRESS;
    end else begin
      cur <= next_cur;
    end
  end

  // data-space read mux
  always_comb begin
    ds_rdata = 8'h00;
    if (ds_gpr) begin
      ds_rdata = gp.rd_b_data;
    end else if (ds_addr == `DS_SP_LOW) begin
      ds_rdata = cur.sp[7:0];
    end else if (ds_addr == `DS_SP_HIGH) begin
      ds_rdata = {5'b00000, cur.sp[10:8]};
    end else if (ds_addr == `DS_STATUS) begin
      ds_rdata = cur.flags;
    end
  end

  // outputs
  assign src_a_byte = gp.rd_a_data;
  assign src_b_byte = gp.rd_b_data;
  assign src_a_word = gp.rd_w_data;
  assign irq_accept_ok = irq_request_any && cur.flags[`FLAG_IE];
  assign stack_ptr = cur.sp;
  assign status_flags_reg = cur.flags;
endmodule

//--- cpu_state_core_asserts.sv
// assertion checker for the cpu state block
`timescale 1ns/1ns
`include "cpu_state_cfg.svh"
module cpu_state_core_asserts
  import cpu_state_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // watched controls
  input wire logic global_irq_set_op,
  input wire logic global_irq_clear_op,
  input wire logic irq_taken,
  input wire logic interrupt_exit,
  input wire logic irq_request_any,
  input wire sp_op_t sp_op,
  input wire logic ds_we,
  input wire logic ds_re,
  input wire logic [7:0] ds_addr,
  // watched results
  input wire logic irq_accept_ok,
  input wire logic [10:0] stack_ptr,
  input wire logic [7:0] ds_rdata,
  input wire logic [7:0] status_flags_reg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // stack steps without a competing data write
  sequence s_quiet;
    !ds_we;
  endsequence
  sequence s_push2;
    sp_op == SP_DEC2 ##0 s_quiet;
  endsequence
  sequence s_pop2;
    sp_op == SP_INC2 ##0 s_quiet;
  endsequence
  AST_SIGN: assert property (status_flags_reg[4] == (status_flags_reg[2] ^ status_flags_reg[3]))
    else $error("sign flag wrong");
  AST_GATE: assert property (irq_accept_ok == (irq_request_any && status_flags_reg[7]))
    else $error("accept not gated");
  AST_ENTRY: assert property (irq_taken && !global_irq_set_op && !interrupt_exit && !ds_we
    |=> !status_flags_reg[7]) else $error("enable kept on entry");
  AST_EXIT: assert property (interrupt_exit && !irq_taken && !global_irq_clear_op && !ds_we
    |=> status_flags_reg[7]) else $error("enable not set on exit");
  AST_SET: assert property (global_irq_set_op && !global_irq_clear_op && !irq_taken && !ds_we
    |=> status_flags_reg[7]) else $error("set op ignored");
  AST_CLEAR: assert property (global_irq_clear_op && !interrupt_exit && !ds_we
    |=> !status_flags_reg[7]) else $error("clear op ignored");
  AST_PUSH2: assert property (s_push2 |=> stack_ptr == $past(stack_ptr) - 11'd2)
    else $error("push of two wrong");
  AST_POP2: assert property (s_pop2 |=> stack_ptr == $past(stack_ptr) + 11'd2)
    else $error("pop of two wrong");
  AST_RESET: assert property ($rose(rst_n) |-> stack_ptr == `LAST_SRAM_ADDRESS
    && status_flags_reg == `STATUS_RESET) else $error("reset state wrong");
  AST_SPH: assert property (ds_re && ds_addr == `DS_SP_HIGH |-> ds_rdata == {5'h00, stack_ptr[10:8]})
    else $error("high stack byte wrong");
endmodule
bind cpu_state_core cpu_state_core_asserts u_asserts (.sys_clk, .rst_n, .global_irq_set_op,
  .global_irq_clear_op, .irq_taken, .interrupt_exit, .irq_request_any, .sp_op, .ds_we, .ds_re,
  .ds_addr, .irq_accept_ok, .stack_ptr, .ds_rdata, .status_flags_reg);

//--- alu_add_model.sv
// byte adder standing in for the datapath side
`timescale 1ns/1ns
module alu_add_model (
  // operands
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  // sum and carries
  output logic [15:0] sum,
  output logic carry,
  output logic half,
  output logic overflow
);
  // byte add with nibble and sign carries
  assign {carry, sum[7:0]} = op_a + op_b;
  assign sum[15:8] = 8'h00;
  assign half = (op_a[3:0] + op_b[3:0]) > 5'h0f;
  assign overflow = (op_a[7] == op_b[7]) && (sum[7] != op_a[7]);
endmodule

//--- cpu_state_core_tb.sv
// self-checking bench for the cpu state block
`timescale 1ns/1ns
module cpu_state_core_tb;
  import cpu_state_pkg::*;
  logic sys_clk, rst_n, result_we, result_wide, alu_update, alu_carry, alu_half, alu_overflow;
  logic bit_to_flag_copy, flag_to_bit_copy, global_irq_set_op, global_irq_clear_op, irq_taken;
  logic interrupt_exit, irq_request_any, irq_accept_ok, ds_we, ds_re, ds_hit, alu_result_wide;
  logic [4:0] src_a_sel, src_b_sel, result_sel;
  logic [7:0] src_a_byte, src_b_byte, alu_flag_mask, ds_addr, ds_wdata, ds_rdata, op_a, op_b;
  logic [7:0] status_flags_reg;
  logic [15:0] src_a_word, result_data, alu_result, ptr_addr;
  logic [2:0] copy_bit_sel;
  logic [1:0] ptr_sel;
  logic [5:0] ptr_disp;
  logic [10:0] stack_ptr;
  sp_op_t sp_op;
  ptr_mode_t ptr_mode;
  int err_total, checked;
  alu_add_model u_alu (.op_a, .op_b, .sum(alu_result), .carry(alu_carry), .half(alu_half),
    .overflow(alu_overflow));
  cpu_state_core uut (.sys_clk, .rst_n, .src_a_sel, .src_b_sel, .src_a_byte, .src_b_byte,
    .src_a_word, .result_we, .result_wide, .result_sel, .result_data, .alu_update,
    .alu_flag_mask, .alu_carry, .alu_half, .alu_overflow, .alu_result, .alu_result_wide,
    .bit_to_flag_copy, .flag_to_bit_copy, .copy_bit_sel, .global_irq_set_op,
    .global_irq_clear_op, .irq_taken, .interrupt_exit, .irq_request_any, .irq_accept_ok,
    .sp_op, .stack_ptr, .ptr_sel, .ptr_mode, .ptr_disp, .ptr_addr, .ds_we, .ds_re, .ds_addr,
    .ds_wdata, .ds_rdata, .ds_hit, .status_flags_reg);
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // drop every strobe except ds_re
  task automatic drop;
    {result_we, alu_update, bit_to_flag_copy, flag_to_bit_copy, ds_we} = '0;
    {global_irq_set_op, global_irq_clear_op, irq_taken, interrupt_exit} = '0;
    sp_op = SP_HOLD;
    ptr_mode = PTR_NONE;
  endtask
  // one edge takes the request
  task automatic tick;
    @(negedge sys_clk);
    drop;
  endtask
  task automatic ds_wr(input logic [7:0] a, input logic [7:0] d);
    ds_addr = a;
    ds_wdata = d;
    ds_we = 1'b1;
    tick;
  endtask
  task automatic ds_chk(input logic [7:0] a, input logic [7:0] exp);
    ds_addr = a;
    ds_re = 1'b1;
    #1;
    chk("data read", {8'h00, exp}, {8'h00, ds_rdata});
    ds_re = 1'b0;
  endtask
  task automatic t_reset;
    chk("flags", 16'h0000, {8'h00, status_flags_reg});
    chk("stack", 16'h04ff, {5'h00, stack_ptr});
    ds_chk(8'h5d, 8'hff);
  endtask
  task automatic t_regs;
    result_sel = 5'h1a;
    result_data = 16'h1234;
    result_wide = 1'b1;
    result_we = 1'b1;
    tick;
    result_wide = 1'b0;
    src_a_sel = 5'h1a;
    src_b_sel = 5'h1b;
    ptr_disp = 6'h05;
    #1;
    chk("operand b", 16'h0012, {8'h00, src_b_byte});
    chk("pair", 16'h1234, src_a_word);
    chk("low byte", 16'h0034, {8'h00, src_a_byte});
    chk("disp", 16'h1239, ptr_addr);
    ds_chk(8'h1b, 8'h12);
    ptr_disp = 6'h00;
    ptr_mode = PTR_POST_INC;
    tick;
    chk("post inc", 16'h1235, src_a_word);
    ptr_mode = PTR_PRE_DEC;
    #1;
    chk("pre dec", 16'h1234, ptr_addr);
    tick;
    chk("after dec", 16'h1234, src_a_word);
  endtask
  task automatic t_alu;
    alu_flag_mask = 8'h2f;
    op_a = 8'h7f;
    op_b = 8'h01;
    alu_update = 1'b1;
    tick;
    chk("add flags", 16'h002c, {8'h00, status_flags_reg});
    op_a = 8'hff;
    alu_update = 1'b1;
    tick;
    chk("carry flags", 16'h0023, {8'h00, status_flags_reg});
  endtask
  task automatic t_copy;
    copy_bit_sel = 3'd2;
    bit_to_flag_copy = 1'b1;
    tick;
    chk("copy store", 16'h0001, {15'h0000, status_flags_reg[6]});
    src_a_sel = 5'h00;
    copy_bit_sel = 3'd3;
    flag_to_bit_copy = 1'b1;
    tick;
    chk("copy back", 16'h0008, {8'h00, src_a_byte});
  endtask
  task automatic t_irq;
    ds_wr(8'h5d, 8'h80);
    ds_wr(8'h5e, 8'hff);
    chk("stack set", 16'h0780, {5'h00, stack_ptr});
    ds_chk(8'h5e, 8'h07);
    irq_request_any = 1'b1;
    global_irq_set_op = 1'b1;
    tick;
    chk("accept", 16'h0001, {15'h0000, irq_accept_ok});
    irq_taken = 1'b1;
    sp_op = SP_DEC2;
    tick;
    chk("accept off", 16'h0000, {15'h0000, irq_accept_ok});
    chk("entry stack", 16'h077e, {5'h00, stack_ptr});
    interrupt_exit = 1'b1;
    sp_op = SP_INC2;
    tick;
    chk("exit enable", 16'h0001, {15'h0000, status_flags_reg[7]});
    chk("flags kept", 16'h00e3, {8'h00, status_flags_reg});
    chk("exit stack", 16'h0780, {5'h00, stack_ptr});
    sp_op = SP_DEC1;
    tick;
    chk("push", 16'h077f, {5'h00, stack_ptr});
    sp_op = SP_INC1;
    tick;
    chk("pop", 16'h0780, {5'h00, stack_ptr});
    global_irq_clear_op = 1'b1;
    tick;
    chk("cleared", 16'h0000, {15'h0000, status_flags_reg[7]});
    irq_request_any = 1'b0;
  endtask
  task automatic t_ds;
    ds_wr(8'h5f, 8'h1c);
    ds_chk(8'h5f, 8'h0c);
    chk("hit flags", 16'h0001, {15'h0000, ds_hit});
    ds_wr(8'h40, 8'h55);
    ds_chk(8'h40, 8'h00);
    chk("hit unmapped", 16'h0000, {15'h0000, ds_hit});
  endtask
  task automatic report_and_stop;
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    {src_a_sel, src_b_sel, result_sel, result_wide, result_data, alu_flag_mask} = '0;
    {alu_result_wide, copy_bit_sel, irq_request_any, ptr_sel, ptr_disp, ds_re} = '0;
    {ds_addr, ds_wdata, op_a, op_b} = '0;
    drop;
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    t_reset;
    t_regs;
    t_alu;
    t_copy;
    t_irq;
    t_ds;
    report_and_stop;
  end
  // watchdog
  initial begin
    #20000;
    err_total++;
    report_and_stop;
  end
endmodule
